// *** block_clock_reset_control.sv ***
// clock select/enable circuits and reset unit of one configurable logic block
// assumes global clocks, routed inputs and reset arrive as levels on core_clk;
// each produced clock is a one-cycle enable pulse on core_clk
//
// Decided for this implementation: the AHB-Lite register port and the address map.
module block_clock_reset_control #(
   parameter int NUM_GCLK = 8
) (
   input  wire logic                      core_clk,        // system clock
   input  wire logic                      resetn,          // sync reset, low
   input  wire clkrst_pkg::ahb_req_t      ahb_req,         // ahb-lite request
   output      clkrst_pkg::ahb_rsp_t      ahb_rsp,         // ahb-lite response
   input  wire logic [NUM_GCLK-1:0]       gclk,            // global clock levels
   input  wire logic [3:0]                routed_control_inputs, // routed inputs
   input  wire logic                      routed_rst,      // routed reset
   input  wire logic                      st_irq_req,      // status interrupt request
   output      clkrst_pkg::clk_tick_t     ticks,           // gated clock pulses
   output      clkrst_pkg::rst_out_t      resets,          // subunit resets
   output      logic                      sc_irq,          // gated interrupt
   output      logic [6:0]                mask_period,     // mask / count period
   output      logic [7:0]                aux_ctl          // auxiliary control
);
   import clkrst_pkg::*;

   if (NUM_GCLK < 1 || NUM_GCLK > 8) begin : g_bad
      $error("NUM_GCLK must lie in 1..8");
   end

   typedef struct packed {
      clk_cfg_t [NUM_CIRC-1:0] cfg;
      misc_t                   misc;
      logic [NUM_CIRC-1:0]     fw_rst;
      logic [PER_W-1:0]        mask_per;
      logic [AUX_W-1:0]        aux;
      logic                    ext_s1;
      logic                    ext_s2;
      logic [NUM_CIRC-1:0]     src_prev;
      logic [NUM_CIRC-1:0]     en_prev;
      logic                    dph_wr;
      logic [7:0]              dph_addr;
      ahb_rsp_t                rsp;
      clk_tick_t               tick;
      rst_out_t                rst;
      logic                    irq;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic [NUM_CIRC-1:0] cur;
   logic [NUM_CIRC-1:0] en_val;
   logic [NUM_CIRC-1:0] edge_hit;
   logic [NUM_CIRC-1:0] gate;
   logic                ext_lvl;
   logic                fifo0_edge;
   logic                fifo1_edge;
   logic                route_use;
   logic                acc;
   logic [31:0]         status_word;

   // level of the selected source; unused codes give a dead clock
   function automatic logic src_level(logic [3:0] sel, logic [NUM_GCLK-1:0] g,
                                      logic ext);
      logic lv;
      lv = 1'b0;
      if (sel < 4'(NUM_GCLK))
         lv = g[sel[2:0]];
      else if (sel == SRC_EXT)
         lv = ext;
      return lv;
   endfunction

   // active clock edge of the selected source; inversion picks the falling edge
   function automatic logic clk_edge(logic [3:0] sel, logic prev, logic now,
                                     logic inv);
      logic hit;
      hit = 1'b0;
      if (sel == SRC_BUS)
         hit = 1'b1;
      else if (sel < 4'(NUM_GCLK) || sel == SRC_EXT)
         hit = inv ? (prev & ~now) : (~prev & now);
      return hit;
   endfunction

   function automatic logic gate_fn(en_mode_t m, logic e, logic eprev);
      logic g;
      case (m)
         EN_OFF:     g = 1'b0;
         EN_ON:      g = 1'b1;
         EN_POSEDGE: g = e & ~eprev;
         EN_LEVEL:   g = e;
         default:    g = 1'b0;
      endcase
      return g;
   endfunction

   function automatic logic is_cfg(logic [7:0] a);
      return (a & CFG_DEC_MASK) == OFF_CLKCFG;
   endfunction

   function automatic logic [31:0] reg_read(state_t st, logic [7:0] a,
                                            logic [31:0] stat);
      logic [31:0] d;
      d = 32'h0;
      if (is_cfg(a))
         d = 32'(st.cfg[a[3:2]]);
      else begin
         case (a)
            OFF_MISC:    d = 32'(st.misc);
            OFF_FWRST:   d = 32'(st.fw_rst);
            OFF_MASKPER: d = 32'(st.mask_per);
            OFF_AUXCTL:  d = 32'(st.aux);
            OFF_STATUS:  d = stat;
            default:     d = 32'h0;
         endcase
      end
      return d;
   endfunction

   always_comb begin
      s_nxt = s_r;
      // the first sync stage feeds only the second
      s_nxt.ext_s1 = routed_control_inputs[s_r.misc.ext_sel];
      s_nxt.ext_s2 = s_r.ext_s1;
      ext_lvl = s_r.misc.ext_sync ? s_r.ext_s2
                                  : routed_control_inputs[s_r.misc.ext_sel];

      for (int i = 0; i < NUM_CIRC; i++) begin
         cur[i] = src_level(s_r.cfg[i].clk_sel, gclk, ext_lvl);
         en_val[i] = routed_control_inputs[s_r.cfg[i].en_sel]
                     ^ s_r.cfg[i].en_inv;
         edge_hit[i] = clk_edge(s_r.cfg[i].clk_sel, s_r.src_prev[i], cur[i],
                                s_r.cfg[i].clk_inv);
         gate[i] = gate_fn(s_r.cfg[i].mode, en_val[i], s_r.en_prev[i]);
         s_nxt.tick.unit[i] = edge_hit[i] & gate[i];
         s_nxt.src_prev[i] = cur[i];
         // enable history only advances on the circuit's own clock
         if (edge_hit[i])
            s_nxt.en_prev[i] = en_val[i];
      end

      // fifo clocks reuse the datapath source and enable, own polarity
      fifo0_edge = s_r.misc.fifo0_fast ? 1'b1
                 : clk_edge(s_r.cfg[CI_DP].clk_sel, s_r.src_prev[CI_DP], cur[CI_DP],
                            s_r.cfg[CI_DP].clk_inv ^ s_r.misc.fifo0_inv);
      fifo1_edge = s_r.misc.fifo1_fast ? 1'b1
                 : clk_edge(s_r.cfg[CI_DP].clk_sel, s_r.src_prev[CI_DP], cur[CI_DP],
                            s_r.cfg[CI_DP].clk_inv ^ s_r.misc.fifo1_inv);
      s_nxt.tick.fifo0 = fifo0_edge & gate[CI_DP];
      s_nxt.tick.fifo1 = fifo1_edge & gate[CI_DP];

      // legacy style leaves subunits on firmware resets only
      route_use = s_r.misc.reset_style_select & routed_rst;
      s_nxt.rst.la0 = s_r.fw_rst[CI_LA0] | route_use;
      s_nxt.rst.la1 = s_r.fw_rst[CI_LA1] | route_use;
      // datapath consumer keeps its data registers and fifo ram on this reset
      s_nxt.rst.dp = s_r.fw_rst[CI_DP] | route_use;
      s_nxt.rst.sc_cnt = s_r.fw_rst[CI_SC] | route_use;
      s_nxt.rst.sc_st = s_r.fw_rst[CI_SC]
                        | (route_use & s_r.misc.st_rst_en);
      s_nxt.rst.sc_ctl = s_r.fw_rst[CI_SC]
                         | (route_use & s_r.misc.ctl_rst_en);

      // the mask register doubles as period, so no interrupt in counter mode
      s_nxt.irq = st_irq_req & s_r.aux[AUX_INT_EN]
                  & ~s_r.misc.counter_mode;

      // register writes land in the data phase; access clock is never gated
      if (s_r.dph_wr) begin
         if (is_cfg(s_r.dph_addr))
            s_nxt.cfg[s_r.dph_addr[3:2]] = clk_cfg_t'(ahb_req.hwdata[CFG_W-1:0]);
         else begin
            case (s_r.dph_addr)
               OFF_MISC:    s_nxt.misc = misc_t'(ahb_req.hwdata[MISC_W-1:0]);
               OFF_FWRST:   s_nxt.fw_rst = ahb_req.hwdata[NUM_CIRC-1:0];
               // retention: only por and software change these two
               OFF_MASKPER: s_nxt.mask_per = ahb_req.hwdata[PER_W-1:0];
               OFF_AUXCTL:  s_nxt.aux = ahb_req.hwdata[AUX_W-1:0];
               default:     s_nxt.fw_rst = s_r.fw_rst;
            endcase
         end
      end

      status_word = {20'h0, routed_control_inputs, routed_rst, s_r.irq,
                     s_r.tick.fifo1, s_r.tick.fifo0, s_r.tick.unit};
      acc = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[HTRANS_ACT];
      s_nxt.dph_wr = acc & ahb_req.hwrite;
      if (acc)
         s_nxt.dph_addr = ahb_req.haddr[7:0];
      // read data taken from next state so a write just before is seen
      if (acc && !ahb_req.hwrite)
         s_nxt.rsp.hrdata = reg_read(s_nxt, ahb_req.haddr[7:0], status_word);
      s_nxt.rsp.hreadyout = 1'b1;
      s_nxt.rsp.hresp = HRESP_OKAY;
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.rsp.hreadyout <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ahb_rsp = s_r.rsp;
   assign ticks = s_r.tick;
   assign resets = s_r.rst;
   assign sc_irq = s_r.irq;
   assign mask_period = s_r.mask_per;
   assign aux_ctl = s_r.aux;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_off_no_clock: assert property (
      s_r.cfg[CI_LA0].mode == EN_OFF |=> !s_r.tick.unit[CI_LA0])
      else $error("clock issued in off mode");

   a_on_bus_run: assert property (
      s_r.cfg[CI_LA0].mode == EN_ON && s_r.cfg[CI_LA0].clk_sel == SRC_BUS
      |=> s_r.tick.unit[CI_LA0])
      else $error("on mode with bus clock missed a clock");

   a_level_gate_low: assert property (
      s_r.cfg[CI_LA0].mode == EN_LEVEL
      && !(routed_control_inputs[s_r.cfg[CI_LA0].en_sel] ^ s_r.cfg[CI_LA0].en_inv)
      |=> !s_r.tick.unit[CI_LA0])
      else $error("level mode clocked with enable low");

   a_posedge_single: assert property (
      s_r.tick.unit[CI_LA0] && s_r.cfg[CI_LA0].mode == EN_POSEDGE
      && $past(s_r.cfg[CI_LA0].mode) == EN_POSEDGE
      |=> !s_r.tick.unit[CI_LA0])
      else $error("posedge mode gave two clocks in a row");

   a_counter_no_irq: assert property (
      s_r.misc.counter_mode |=> !s_r.irq)
      else $error("interrupt raised in counter mode");

   a_retain_mask: assert property (
      routed_rst && s_r.misc.reset_style_select && !s_r.dph_wr
      |=> $stable(s_r.mask_per) && $stable(s_r.aux))
      else $error("retention register changed on routed reset");

   a_status_rst_en: assert property (
      s_r.fw_rst[CI_SC] == 1'b0 && !s_r.misc.st_rst_en |=> !s_r.rst.sc_st)
      else $error("status reset without its enable");

   a_ctl_rst_route: assert property (
      routed_rst && s_r.misc.reset_style_select && s_r.misc.ctl_rst_en
      |=> s_r.rst.sc_ctl && s_r.rst.sc_cnt)
      else $error("control reset missed routed reset");

   a_legacy_no_route: assert property (
      !s_r.misc.reset_style_select && s_r.fw_rst == '0
      |=> !s_r.rst.la0 && !s_r.rst.la1 && !s_r.rst.dp)
      else $error("routed reset used in legacy style");

   a_fifo_fast_bus: assert property (
      s_r.misc.fifo0_fast && s_r.cfg[CI_DP].mode == EN_ON |=> s_r.tick.fifo0)
      else $error("fast fifo missed bus clock");

   a_dead_source: assert property (
      s_r.cfg[CI_LA0].clk_sel > SRC_EXT |=> !s_r.tick.unit[CI_LA0])
      else $error("unused source code produced a clock");

   a_ext_direct: assert property (
      s_r.cfg[CI_LA0].mode == EN_ON && s_r.cfg[CI_LA0].clk_sel == SRC_EXT
      && !s_r.cfg[CI_LA0].clk_inv && !s_r.misc.ext_sync && !s_r.src_prev[CI_LA0]
      && routed_control_inputs[s_r.misc.ext_sel]
      |=> s_r.tick.unit[CI_LA0])
      else $error("external clock rise missed");

   a_rise_only: assert property (
      s_r.cfg[CI_LA0].mode == EN_ON && s_r.cfg[CI_LA0].clk_sel == 4'h0
      && !s_r.cfg[CI_LA0].clk_inv && !(gclk[0] && !s_r.src_prev[CI_LA0])
      |=> !s_r.tick.unit[CI_LA0])
      else $error("clock issued without a rising source edge");

   a_invert_fall: assert property (
      s_r.cfg[CI_LA0].mode == EN_ON && s_r.cfg[CI_LA0].clk_sel == 4'h0
      && s_r.cfg[CI_LA0].clk_inv && s_r.src_prev[CI_LA0] && !gclk[0]
      |=> s_r.tick.unit[CI_LA0])
      else $error("inverted clock missed a falling source edge");

   a_level_gate_high: assert property (
      s_r.cfg[CI_LA0].mode == EN_LEVEL && s_r.cfg[CI_LA0].clk_sel == SRC_BUS
      && (routed_control_inputs[s_r.cfg[CI_LA0].en_sel] ^ s_r.cfg[CI_LA0].en_inv)
      |=> s_r.tick.unit[CI_LA0])
      else $error("level mode withheld a clock with enable high");

   a_posedge_held: assert property (
      s_r.cfg[CI_LA0].mode == EN_POSEDGE && s_r.en_prev[CI_LA0]
      |=> !s_r.tick.unit[CI_LA0])
      else $error("posedge mode clocked without a low enable sample");

   a_off_datapath: assert property (
      s_r.cfg[CI_DP].mode == EN_OFF
      |=> !s_r.tick.unit[CI_DP] && !s_r.tick.fifo0 && !s_r.tick.fifo1)
      else $error("datapath or fifo clock issued in off mode");

   a_fifo_follow: assert property (
      !s_r.misc.fifo1_fast && !s_r.misc.fifo1_inv
      |=> s_r.tick.fifo1 == s_r.tick.unit[CI_DP])
      else $error("fifo clock strayed from datapath clock");

   a_fifo_inverted: assert property (
      s_r.misc.fifo1_inv && !s_r.misc.fifo1_fast && s_r.cfg[CI_DP].clk_sel != SRC_BUS
      |=> !(s_r.tick.fifo1 && s_r.tick.unit[CI_DP]))
      else $error("inverted fifo clock met the datapath clock");

   a_fw_reset_dp: assert property (
      s_r.fw_rst[CI_DP] |=> s_r.rst.dp)
      else $error("datapath firmware reset not applied");

   a_fw_reset_sc: assert property (
      s_r.fw_rst[CI_SC] |=> s_r.rst.sc_cnt && s_r.rst.sc_st && s_r.rst.sc_ctl)
      else $error("status control firmware reset not applied");

   a_route_all: assert property (
      routed_rst && s_r.misc.reset_style_select
      |=> s_r.rst.la0 && s_r.rst.la1 && s_r.rst.dp && s_r.rst.sc_cnt)
      else $error("routed reset missed a subunit");

   a_status_route: assert property (
      routed_rst && s_r.misc.reset_style_select && s_r.misc.st_rst_en
      |=> s_r.rst.sc_st)
      else $error("status reset missed routed reset");

   a_ctl_no_en: assert property (
      !s_r.fw_rst[CI_SC] && !s_r.misc.ctl_rst_en |=> !s_r.rst.sc_ctl)
      else $error("control reset without its enable");

   a_legacy_sc: assert property (
      !s_r.misc.reset_style_select && !s_r.fw_rst[CI_SC]
      |=> !s_r.rst.sc_cnt && !s_r.rst.sc_st && !s_r.rst.sc_ctl)
      else $error("routed reset reached status control in legacy style");

   a_irq_enabled: assert property (
      st_irq_req && s_r.aux[AUX_INT_EN] && !s_r.misc.counter_mode |=> s_r.irq)
      else $error("enabled interrupt not raised");
endmodule

// *** clkrst_pkg.sv ***
// constants, register map and carrier types of the block clock/reset control
// assumes an ahb-lite master on core_clk and synchronous routed inputs
// Contract
// - in counter mode mask register is the period; no interrupt output.
// - ten clock sources: eight global clocks, application bus clock, external clock.
// - four clock circuits (two logic arrays, datapath, status/control) and one reset unit.
// - external clock picked from routed inputs, optionally synchronised first.
// - each circuit picks its enable from any of four routed inputs.
// - each circuit can invert its selected clock.
// - each circuit can invert its selected enable.
// - two-bit enable mode off/on/posedge/level, resets to off, off gives no clock.
// - on mode passes the selected clock regardless of enable.
// - posedge mode gives one clock per enable rise; enable at most half rate.
// - level mode passes clocks while enable is high.
// - application bus clock gated like globals, separate from register access clock.
// - datapath generator gives three clocks: datapath and two fifos.
// - fifo clocks follow datapath clock; per-fifo inversion option.
// - fifo fast option clocks the fifo from the bus clock.
// - reset style bit: 0 legacy default, 1 standard with routed subunit resets.
// - routed reset to logic arrays and counter; firmware reset per subunit.
// - routed datapath reset spares the two data registers.
// - fifo storage is not cleared by reset and is unknown afterwards.
// - status and control share routed reset, each with own enable; count reset has no enable.
// - mask/period and auxiliary control keep contents through routed reset.
package clkrst_pkg;
   localparam int        NUM_CIRC    = 4;
   localparam int        NUM_RC      = 4;
   localparam int        CI_LA0      = 0;
   localparam int        CI_LA1      = 1;
   localparam int        CI_DP       = 2;
   localparam int        CI_SC       = 3;
   localparam logic [3:0] SRC_BUS    = 4'h8;
   localparam logic [3:0] SRC_EXT    = 4'h9;
   localparam logic [7:0] OFF_CLKCFG = 8'h00;
   localparam logic [7:0] CFG_DEC_MASK = 8'hf3;
   localparam logic [7:0] OFF_MISC   = 8'h10;
   localparam logic [7:0] OFF_FWRST  = 8'h14;
   localparam logic [7:0] OFF_MASKPER = 8'h18;
   localparam logic [7:0] OFF_AUXCTL = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam int        AUX_INT_EN  = 4;
   localparam int        PER_W       = 7;
   localparam int        AUX_W       = 8;
   localparam int        HTRANS_ACT  = 1;
   localparam logic      HRESP_OKAY  = 1'b0;

   typedef enum logic [1:0] {EN_OFF, EN_ON, EN_POSEDGE, EN_LEVEL} en_mode_t;

   typedef struct packed {
      en_mode_t   mode;
      logic       en_inv;
      logic [1:0] en_sel;
      logic       clk_inv;
      logic [3:0] clk_sel;
   } clk_cfg_t;

   typedef struct packed {
      logic       ctl_rst_en;
      logic       st_rst_en;
      logic       counter_mode;
      logic       reset_style_select;
      logic       fifo1_fast;
      logic       fifo0_fast;
      logic       fifo1_inv;
      logic       fifo0_inv;
      logic       ext_sync;
      logic [1:0] ext_sel;
   } misc_t;

   localparam int CFG_W  = $bits(clk_cfg_t);
   localparam int MISC_W = $bits(misc_t);

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } ahb_req_t;

   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } ahb_rsp_t;

   typedef struct packed {
      logic [NUM_CIRC-1:0] unit;
      logic                fifo0;
      logic                fifo1;
   } clk_tick_t;

   typedef struct packed {
      logic la0;
      logic la1;
      logic dp;
      logic sc_cnt;
      logic sc_st;
      logic sc_ctl;
   } rst_out_t;
endpackage

// *** fabric_model.sv ***
// routing fabric and global clock tree facing the clock/reset control
// assumes the bench changes its commands right after a rising core_clk edge
module fabric_model (
   input  wire logic       core_clk,  // system clock
   input  wire logic [3:0] rc_level,  // commanded routed levels
   input  wire logic       rc_toggle, // slow toggle on routed input 0
   input  wire logic       rst_cmd,   // commanded routed reset
   input  wire logic       irq_cmd,   // commanded status request
   output      logic [7:0] gclk,      // global clock levels
   output      logic [3:0] rc,        // routed control inputs
   output      logic       rrst,      // routed reset
   output      logic       irq        // status interrupt request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt  = 8'h00;
   logic       rrst_q = 1'b0;
   logic       irq_q  = 1'b0;
   always @(posedge core_clk) begin
      cnt    <= cnt + 8'h01;
      rrst_q <= rst_cmd;
      irq_q  <= irq_cmd;
   end
   // divided clocks: bit i has a period of 2^(i+1) cycles
   assign gclk = cnt;
   // period of 8 cycles, slow enough for every source in use
   assign rc   = rc_level ^ {3'h0, rc_toggle & cnt[2]};
   assign rrst = rrst_q;
   assign irq  = irq_q;
endmodule

// *** block_clock_reset_control_tb_top.sv ***
// self-checking bench for the block clock/reset control
// assumes fabric_model beside the design and one ahb-lite master
module block_clock_reset_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import clkrst_pkg::*;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] r;
      logic [3:0]  rc;
      logic        tg;
      int          nt;
   } row_t;
   logic        core_clk  = 1'b0;
   logic        resetn    = 1'b0;
   ahb_req_t    req       = '0;
   ahb_req_t    bus;
   ahb_rsp_t    rsp;
   logic [7:0]  gclk;
   logic [3:0]  rc;
   logic [3:0]  rc_level  = 4'h0;
   logic        rc_toggle = 1'b0;
   logic        rst_cmd   = 1'b0;
   logic        irq_cmd   = 1'b0;
   logic        rrst;
   logic        irq;
   clk_tick_t   ticks;
   rst_out_t    resets;
   logic        sc_irq;
   logic [6:0]  mask_period;
   logic [7:0]  aux_ctl;
   logic [31:0] q;
   int          n;
   int          num_errors = 0;
   int          checked    = 0;
   row_t        rows [23];

   always #5 core_clk = ~core_clk;
   always_comb begin
      bus        = req;
      bus.hready = rsp.hreadyout;
   end

   fabric_model u_fab (.core_clk(core_clk), .rc_level(rc_level), .rc_toggle(rc_toggle),
      .rst_cmd(rst_cmd), .irq_cmd(irq_cmd), .gclk(gclk), .rc(rc), .rrst(rrst), .irq(irq));

   block_clock_reset_control #(.NUM_GCLK(8)) u_dut (.core_clk(core_clk), .resetn(resetn),
      .ahb_req(bus), .ahb_rsp(rsp), .gclk(gclk), .routed_control_inputs(rc),
      .routed_rst(rrst), .st_irq_req(irq), .ticks(ticks), .resets(resets),
      .sc_irq(sc_irq), .mask_period(mask_period), .aux_ctl(aux_ctl));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("errors %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (rsp.hreadyout !== 1'b1 && k < 20);
      if (rsp.hreadyout !== 1'b1) begin
         num_errors++;
         final_report();
      end
   endtask

   // single word transfer; ends just after the edge closing the data phase
   // nothing inside writes a register that the bus writes here
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      req.hsel   <= 1'b1;
      req.haddr  <= {24'h0, a};
      req.htrans <= 2'b10;
      req.hwrite <= wr;
      req.hsize  <= 3'b010;
      wait_rdy();
      req.htrans <= 2'b00;
      req.hwdata <= d;
      wait_rdy();
      q = rsp.hrdata;
   endtask

   // counts pulses of one produced clock over 32 cycles after settling
   task automatic count(input int idx, output int c);
      logic [5:0] v;
      c = 0;
      repeat (6) @(posedge core_clk);
      repeat (32) begin
         @(negedge core_clk);
         v = {ticks.fifo1, ticks.fifo0, ticks.unit};
         if (v[idx] === 1'b1) c++;
      end
   endtask

   task automatic settle();
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      final_report();
   end

   initial begin
      rows = '{
         '{8'h00, 32'h000, 32'h000, 4'h0, 1'b0, 0},
         '{8'h00, 32'h100, 32'h100, 4'h0, 1'b0, 16},
         '{8'h00, 32'hfffff110, 32'h110, 4'h0, 1'b0, 16},
         '{8'h00, 32'h101, 32'h101, 4'h0, 1'b0, 8},
         '{8'h00, 32'h10a, 32'h10a, 4'h0, 1'b0, 0},
         '{8'h00, 32'h108, 32'h108, 4'h0, 1'b0, 32},
         '{8'h00, 32'h308, 32'h308, 4'h0, 1'b0, 0},
         '{8'h00, 32'h308, 32'h308, 4'h1, 1'b0, 32},
         '{8'h00, 32'h388, 32'h388, 4'h0, 1'b0, 32},
         '{8'h00, 32'h3a8, 32'h3a8, 4'h1, 1'b0, 32},
         '{8'h00, 32'h3a8, 32'h3a8, 4'h2, 1'b0, 0},
         '{8'h00, 32'h208, 32'h208, 4'h0, 1'b1, 4},
         '{8'h00, 32'h308, 32'h308, 4'h0, 1'b1, 16},
         '{8'h00, 32'h109, 32'h109, 4'h0, 1'b1, 4},
         '{8'h10, 32'h005, 32'h005, 4'h0, 1'b1, 0},
         '{8'h10, 32'h004, 32'h004, 4'h0, 1'b1, 4},
         '{8'h04, 32'h108, 32'h108, 4'h0, 1'b0, 32},
         '{8'h08, 32'h101, 32'h101, 4'h0, 1'b0, 8},
         '{8'h0c, 32'h110, 32'h110, 4'h0, 1'b0, 16},
         '{8'h14, 32'h000, 32'h000, 4'h0, 1'b0, 32},
         '{8'h18, 32'hffffffff, 32'h7f, 4'h0, 1'b1, 8},
         '{8'h1c, 32'hffffffff, 32'hff, 4'h0, 1'b1, 16},
         '{8'h30, 32'hffffffff, 32'h00, 4'h0, 1'b1, 4}};
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      xfer(1'b0, 8'h00, 32'h0);
      chk("clkcfg after reset", q, 32'h0);
      xfer(1'b0, 8'h10, 32'h0);
      chk("misc after reset", q, 32'h0);
      foreach (rows[i]) begin
         rc_level  <= rows[i].rc;
         rc_toggle <= rows[i].tg;
         xfer(1'b1, rows[i].a, rows[i].d);
         xfer(1'b0, rows[i].a, 32'h0);
         chk("readback", q, rows[i].r);
         count(int'(rows[i].a[3:2]), n);
         chk("tick count", 32'(n), 32'(rows[i].nt));
      end
      // fifo0 fast runs at bus rate, fifo1 inverted still ticks once per gclk1 period
      xfer(1'b1, 8'h10, 32'h030);
      count(4, n);
      chk("fifo0 fast ticks", 32'(n), 32'd32);
      count(5, n);
      chk("fifo1 ticks", 32'(n), 32'd8);
      xfer(1'b1, 8'h14, 32'hf);
      settle();
      chk("firmware resets", {26'h0, resets}, 32'h3f);
      xfer(1'b1, 8'h14, 32'h0);
      rst_cmd <= 1'b1;
      settle();
      chk("legacy routed reset", {26'h0, resets}, 32'h0);
      xfer(1'b1, 8'h10, 32'h280);
      irq_cmd <= 1'b1;
      settle();
      chk("standard routed reset", {26'h0, resets}, 32'h3e);
      chk("mask kept", {25'h0, mask_period}, 32'h7f);
      chk("aux kept", {24'h0, aux_ctl}, 32'hff);
      chk("irq enabled", {31'h0, sc_irq}, 32'h1);
      xfer(1'b1, 8'h10, 32'h480);
      settle();
      chk("control reset enable", {26'h0, resets}, 32'h3d);
      xfer(1'b1, 8'h10, 32'h100);
      rst_cmd <= 1'b0;
      settle();
      chk("irq in counter mode", {31'h0, sc_irq}, 32'h0);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      xfer(1'b0, 8'h18, 32'h0);
      chk("mask after reset", q, 32'h0);
      count(0, n);
      chk("off after reset", 32'(n), 32'd0);
      final_report();
   end
endmodule
